//--- hw/srq_errq.sv
// First-in first-out error queue with a reserved overflow slot.
// Assumes push, pop and clear come from logic on the same clock.
`timescale 1ns/1ps
module srq_errq #(
    parameter int DEPTH = srq_pkg::SRQ_ERRQ_DEPTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Queue control
    input wire logic push,
    input wire logic [srq_pkg::SRQ_CODE_W-1:0] push_code,
    input wire logic pop,
    input wire logic clear,
    // Queue state
    output logic [srq_pkg::SRQ_CODE_W-1:0] head_code,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    import srq_pkg::*;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(DEPTH);

    logic [SRQ_CODE_W-1:0] mem [DEPTH];
    logic [PW-1:0] rd_q, wr_q;
    logic [CW-1:0] cnt_q;
    logic pop_ok, push_ok;
    logic [CW-1:0] base_cnt;
    logic [PW-1:0] base_wr, base_rd;
    logic [SRQ_CODE_W-1:0] push_val;

    function automatic logic [PW-1:0] wrap_inc(logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : wrap_inc

    always_comb begin
        pop_ok = pop && (cnt_q != '0) && !clear;
        base_cnt = clear ? '0 : cnt_q - CW'(pop_ok);
        base_wr = clear ? '0 : wr_q;
        base_rd = clear ? '0 : (pop_ok ? wrap_inc(rd_q) : rd_q);
        // Once the last free slot is reached the error itself is dropped
        // and the overflow code takes its place.
        push_ok = push && (base_cnt < CW'(DEPTH));
        push_val = (base_cnt < CW'(DEPTH - 1)) ? push_code : ERR_OVERFLOW;
    end

    always_ff @(posedge clock) begin
        if (push_ok) begin
            mem[base_wr] <= push_val;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
        end else begin
            rd_q <= base_rd;
            wr_q <= push_ok ? wrap_inc(base_wr) : base_wr;
            cnt_q <= base_cnt + CW'(push_ok);
        end
    end

    assign head_code = (cnt_q == '0) ? ERR_NONE : mem[rd_q];
    assign level = cnt_q;

    a_errq_overflow: assert property (
        @(posedge clock) disable iff (!rstn)
        push && !pop && !clear && cnt_q == CW'(DEPTH - 1)
        |=> cnt_q == CW'(DEPTH) && mem[$past(wr_q)] == ERR_OVERFLOW)
        else $error("overflow code not stored in last slot");
    a_errq_full_drop: assert property (
        @(posedge clock) disable iff (!rstn)
        push && !pop && !clear && cnt_q == CW'(DEPTH)
        |=> cnt_q == CW'(DEPTH) && $stable(wr_q))
        else $error("error accepted into a full queue");
    a_errq_clear_empty: assert property (
        @(posedge clock) disable iff (!rstn)
        clear && !push |=> cnt_q == '0 && head_code == ERR_NONE)
        else $error("queue not empty after clear");
endmodule : srq_errq

//--- hw/srq_top.sv
// Status reporting and service request logic of the instrument.
// Assumes the command parser, acquisition logic and output queue run on
// the same clock and present one command per valid cycle.
`timescale 1ns/1ps
module srq_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Command port from the parser
    input wire srq_pkg::srq_req_t req,
    input wire logic after_terminator,
    output srq_pkg::srq_rsp_t rsp_q,
    // Acquisition events and conditions
    input wire logic trigger_evt,
    input wire logic armed_evt,
    input wire logic running,
    input wire logic overload,
    // Standard events, one cycle pulses
    input wire srq_pkg::srq_std_evt_t std_evt,
    // Error reports
    input wire logic err_valid,
    input wire logic [srq_pkg::SRQ_CODE_W-1:0] err_code,
    // Advisory messages
    input wire logic adv_valid,
    input wire logic adv_from_dsp,
    input wire logic [15:0] adv_code,
    // Output queue
    input wire logic oq_has_data,
    output logic oq_clear_q,
    // Controller link
    output logic srq_q
);
    import srq_pkg::*;

    function automatic logic is_cmd(srq_req_t r, srq_cmd_t c);
        return r.valid && (r.code == c);
    endfunction : is_cmd

    // Configuration masks.
    logic [7:0] sre_q;
    logic [7:0] ese_q;
    logic [15:0] operation_mask_command_q;
    // Event registers and latches.
    logic [7:0] std_q;
    logic [15:0] op_q;
    logic trg_q;
    logic arm_q;
    logic msg_q;
    logic [15:0] msg_code_q;
    // Service request state.
    logic rqs_q;
    logic rqs_d;
    logic [7:0] prev_en_q;
    // Live summary.
    logic [7:0] summary;
    logic [7:0] enabled;
    logic master_summary_bit;
    logic rqs_set;
    logic [15:0] op_set;
    logic [7:0] std_set;
    logic cls;
    logic spoll;
    logic [SRQ_CODE_W-1:0] err_head;
    srq_rsp_t rsp_d;

    assign cls = is_cmd(req, CMD_CLS);
    assign spoll = is_cmd(req, CMD_SPOLL);
    // The packed layout puts the four error flags at bits 2 to 5.
    assign std_set = std_evt;

    // Masks.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sre_q <= SRE_RST;
        end else if (is_cmd(req, CMD_SRE_W)) begin
            sre_q <= req.arg[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ese_q <= ESE_RST;
        end else if (is_cmd(req, CMD_ESE_W)) begin
            ese_q <= req.arg[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            operation_mask_command_q <= OPERATION_MASK_COMMAND_RST;
        end else if (is_cmd(req, CMD_OPERATION_MASK_COMMAND_W)) begin
            operation_mask_command_q <= req.arg;
        end
    end

    // Standard events latch whatever the enable mask says; a new event in
    // the same cycle as the clearing query survives it.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            std_q <= STD_RST;
        end else if (is_cmd(req, CMD_ESR_Q) || cls) begin
            std_q <= std_set;
        end else begin
            std_q <= std_q | std_set;
        end
    end

    always_comb begin
        op_set = '0;
        op_set[OP_RUN] = running;
        op_set[OP_ARM] = arm_q;
        op_set[OP_OVLD] = overload;
    end

    // A live condition sets its bit again right after a read; that keeps
    // the register honest about a state that is still present.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            op_q <= '0;
        end else if (is_cmd(req, CMD_OPERATION_READ_QUERY_Q) || cls) begin
            op_q <= op_set;
        end else begin
            op_q <= op_q | op_set;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            trg_q <= 1'b0;
        end else if (trigger_evt) begin
            trg_q <= 1'b1;
        end else if (is_cmd(req, CMD_TER_Q) || cls) begin
            trg_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            arm_q <= 1'b0;
        end else if (armed_evt) begin
            arm_q <= 1'b1;
        end else if (is_cmd(req, CMD_AER_Q) || cls) begin
            arm_q <= 1'b0;
        end
    end

    // The message queue keeps only the newest advisory text.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            msg_q <= 1'b0;
            msg_code_q <= '0;
        end else if (adv_valid) begin
            msg_code_q <= adv_code;
            msg_q <= !adv_from_dsp || (msg_q && !cls);
        end else if (cls) begin
            msg_q <= 1'b0;
            msg_code_q <= '0;
        end
    end

    srq_errq #(
        .DEPTH(SRQ_ERRQ_DEPTH)
    ) u_errq (
        .clock(clock),
        .rstn(rstn),
        .push(err_valid),
        .push_code(err_code),
        .pop(is_cmd(req, CMD_ERR_Q)),
        .clear(cls),
        .head_code(err_head),
        .level()
    );

    // Live status byte without bit six.
    always_comb begin
        summary = '0;
        summary[STB_TRG] = trg_q;
        summary[STB_MSG] = msg_q;
        summary[STB_MAV] = oq_has_data;
        summary[STB_ESB] = |(std_q & ese_q);
        summary[STB_OPERATION_READ_QUERY] = |(op_q & operation_mask_command_q);
    end

    assign enabled = summary & sre_q & ~STB_RQS_MASK;
    assign master_summary_bit = |enabled;
    // Only a newly enabled summary bit requests service, so one event
    // that stays set cannot raise a second request after the poll.
    assign rqs_set = |(enabled & ~prev_en_q);
    assign rqs_d = rqs_set || (rqs_q && !spoll);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            prev_en_q <= '0;
            rqs_q <= 1'b0;
            srq_q <= 1'b0;
        end else begin
            prev_en_q <= enabled;
            rqs_q <= rqs_d;
            srq_q <= rqs_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            oq_clear_q <= 1'b0;
        end else begin
            oq_clear_q <= cls && after_terminator;
        end
    end

    // Query answers, registered one cycle after the command.
    always_comb begin
        rsp_d.valid = req.valid;
        rsp_d.data = '0;
        unique case (req.code)
            CMD_STB_Q: begin
                rsp_d.data = {8'h00, summary | (master_summary_bit ? STB_RQS_MASK : 8'h00)};
            end
            CMD_SPOLL: begin
                rsp_d.data = {8'h00, summary | (rqs_q ? STB_RQS_MASK : 8'h00)};
            end
            CMD_SRE_Q: rsp_d.data = {8'h00, sre_q};
            CMD_ESE_Q: rsp_d.data = {8'h00, ese_q};
            CMD_ESR_Q: rsp_d.data = {8'h00, std_q};
            CMD_OPERATION_MASK_COMMAND_Q: rsp_d.data = operation_mask_command_q;
            CMD_OPERATION_READ_QUERY_Q: rsp_d.data = op_q;
            CMD_TER_Q: rsp_d.data = {15'h0000, trg_q};
            CMD_AER_Q: rsp_d.data = {15'h0000, arm_q};
            CMD_ERR_Q: rsp_d.data = err_head;
            CMD_DSP_Q: rsp_d.data = msg_code_q;
            CMD_NONE, CMD_SRE_W, CMD_ESE_W, CMD_OPERATION_MASK_COMMAND_W, CMD_CLS: begin
                rsp_d.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    a_rqs_on_enable: assert property (
        @(posedge clock) disable iff (!rstn)
        (enabled & ~prev_en_q) != 8'h00 |=> rqs_q && srq_q)
        else $error("enabled summary did not request service");
    a_spoll_clears_rqs: assert property (
        @(posedge clock) disable iff (!rstn)
        spoll && !rqs_set |=> !rqs_q ##0 !srq_q)
        else $error("serial poll left request service set");
    a_spoll_reports_rqs: assert property (
        @(posedge clock) disable iff (!rstn)
        spoll |=> rsp_q.valid && rsp_q.data[STB_RQS] == $past(rqs_q))
        else $error("serial poll did not report request service");
    a_stb_keeps_rqs: assert property (
        @(posedge clock) disable iff (!rstn)
        is_cmd(req, CMD_STB_Q) && rqs_q
        |=> rqs_q && rsp_q.data[STB_RQS] == $past(master_summary_bit))
        else $error("status query disturbed request service");
    a_stb_no_side: assert property (
        @(posedge clock) disable iff (!rstn)
        is_cmd(req, CMD_STB_Q) && !rqs_set |=> rqs_q == $past(rqs_q))
        else $error("status query changed request service");
    a_sre_stored: assert property (
        @(posedge clock) disable iff (!rstn)
        is_cmd(req, CMD_SRE_W) |=> sre_q == $past(req.arg[7:0]))
        else $error("request enable mask not stored");
    a_sre_readback: assert property (
        @(posedge clock) disable iff (!rstn)
        is_cmd(req, CMD_SRE_Q)
        |=> rsp_q.valid && rsp_q.data == {8'h00, $past(sre_q)})
        else $error("request enable mask not read back");
    a_ese_readback: assert property (
        @(posedge clock) disable iff (!rstn)
        is_cmd(req, CMD_ESE_Q)
        |=> rsp_q.valid && rsp_q.data == {8'h00, $past(ese_q)})
        else $error("event enable mask not read back");
    a_mav_follows_oq: assert property (
        @(posedge clock) disable iff (!rstn)
        is_cmd(req, CMD_STB_Q)
        |=> rsp_q.data[STB_MAV] == $past(oq_has_data))
        else $error("message available bit wrong");
    a_trg_latched: assert property (
        @(posedge clock) disable iff (!rstn)
        trigger_evt |=> trg_q ##1 (trg_q || $past(cls)
        || $past(is_cmd(req, CMD_TER_Q))))
        else $error("trigger latch lost");
    a_esr_read_clear: assert property (
        @(posedge clock) disable iff (!rstn)
        is_cmd(req, CMD_ESR_Q) && std_set == 8'h00
        |=> std_q == 8'h00 && rsp_q.data[7:0] == $past(std_q))
        else $error("event register not returned and cleared");
    a_error_mask_esb: assert property (
        @(posedge clock) disable iff (!rstn)
        ese_q == ESE_ERROR_MASK && std_evt.exec_err
        && !is_cmd(req, CMD_ESE_W) |=> summary[STB_ESB])
        else $error("enabled error event gave no event summary");
    a_disabled_latch: assert property (
        @(posedge clock) disable iff (!rstn)
        std_evt.op_done && !ese_q[0] && !is_cmd(req, CMD_ESR_Q) && !cls
        |=> std_q[0])
        else $error("disabled standard event did not latch");
    a_operation_read_query_read_clear: assert property (
        @(posedge clock) disable iff (!rstn)
        is_cmd(req, CMD_OPERATION_READ_QUERY_Q) && op_set == 16'h0000 |=> op_q == 16'h0000)
        else $error("operation register not cleared by read");
    a_run_flag: assert property (
        @(posedge clock) disable iff (!rstn)
        running |=> op_q[OP_RUN])
        else $error("running condition did not set its flag");
    a_overload_flag: assert property (
        @(posedge clock) disable iff (!rstn)
        overload |=> op_q[OP_OVLD])
        else $error("overload condition did not set its flag");
    a_arm_to_operation_read_query: assert property (
        @(posedge clock) disable iff (!rstn)
        armed_evt && operation_mask_command_q[OP_ARM] ##1 !cls && !is_cmd(req, CMD_OPERATION_READ_QUERY_Q)
        |=> op_q[OP_ARM] && summary[STB_OPERATION_READ_QUERY])
        else $error("arm latch did not reach operation summary");
    a_err_answer: assert property (
        @(posedge clock) disable iff (!rstn)
        is_cmd(req, CMD_ERR_Q)
        |=> rsp_q.valid && rsp_q.data == $past(err_head))
        else $error("error read did not return the queue head");
    a_dsp_no_flag: assert property (
        @(posedge clock) disable iff (!rstn)
        adv_valid && adv_from_dsp && !msg_q |=> !msg_q)
        else $error("display message set the message flag");
    a_msg_newest: assert property (
        @(posedge clock) disable iff (!rstn)
        adv_valid |=> msg_code_q == $past(adv_code))
        else $error("message queue did not keep the newest advisory");
    a_cls_clears: assert property (
        @(posedge clock) disable iff (!rstn)
        cls && !trigger_evt && !armed_evt && std_set == 8'h00
        |=> !trg_q && !arm_q && std_q == 8'h00
        && oq_clear_q == $past(after_terminator))
        else $error("clear did not empty event registers");
    a_oq_clear_only: assert property (
        @(posedge clock) disable iff (!rstn)
        !(cls && after_terminator) |=> !oq_clear_q)
        else $error("output queue cleared without a clear command");
    a_srq_line: assert property (
        @(posedge clock) disable iff (!rstn)
        srq_q == rqs_q)
        else $error("service request line differs from request service");
endmodule : srq_top

//--- shared/srq_pkg.sv
// Constants, commands and carrier types of the status reporting block.
// Assumes one instrument clock; all users import this package.
package srq_pkg;
    // Error queue.
    localparam int SRQ_ERRQ_DEPTH = 30;
    localparam int SRQ_CODE_W = 16;
    localparam logic [15:0] ERR_OVERFLOW = 16'h015e;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    // Status byte bit positions.
    localparam int STB_TRG = 0;
    localparam int STB_MSG = 2;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_RQS = 6;
    localparam int STB_OPERATION_READ_QUERY = 7;
    // Operation register bit positions.
    localparam int OP_RUN = 3;
    localparam int OP_ARM = 5;
    localparam int OP_OVLD = 11;
    // Reset values and fixed masks.
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam logic [15:0] OPERATION_MASK_COMMAND_RST = 16'h0000;
    localparam logic [7:0] STD_RST = 8'h80;
    localparam logic [7:0] STB_RQS_MASK = 8'h40;
    localparam logic [7:0] ESE_ERROR_MASK = 8'h3c;

    typedef enum logic [3:0] {
        CMD_NONE, CMD_STB_Q, CMD_SPOLL, CMD_SRE_W, CMD_SRE_Q, CMD_ESE_W,
        CMD_ESE_Q, CMD_ESR_Q, CMD_OPERATION_MASK_COMMAND_W, CMD_OPERATION_MASK_COMMAND_Q, CMD_OPERATION_READ_QUERY_Q,
        CMD_TER_Q, CMD_AER_Q, CMD_ERR_Q, CMD_DSP_Q, CMD_CLS
    } srq_cmd_t;

    typedef struct packed {
        logic valid;
        srq_cmd_t code;
        logic [15:0] arg;
    } srq_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } srq_rsp_t;

    // Field order fixes the bit weights, most significant first.
    typedef struct packed {
        logic power_on;
        logic user_req;
        logic cmd_err;
        logic exec_err;
        logic dev_err;
        logic query_err;
        logic req_ctrl;
        logic op_done;
    } srq_std_evt_t;
endpackage : srq_pkg

//--- test/srq_host_model.sv
// Behavioural controller that sends commands and collects the answers.
// Assumes the block answers a query within three clocks of taking it.
`timescale 1ns/1ps
module srq_host_model (
    // Clock
    input wire logic clock,
    // Command link
    output srq_pkg::srq_req_t req,
    input wire srq_pkg::srq_rsp_t rsp_q
);
    import srq_pkg::*;

    initial req = '0;

    // Mask writes and read-backs go through here like any command.
    task automatic send(input srq_cmd_t c, input logic [15:0] a,
                        output logic [15:0] d, output logic got);
        got = 1'b0;
        d = 16'h0000;
        @(posedge clock);
        req <= '{valid: 1'b1, code: c, arg: a};
        @(posedge clock);
        req <= '0;
        // Writes never answer, so the wait simply runs out for them.
        for (int i = 0; i < 3 && !got; i++) begin
            #1;
            if (rsp_q.valid === 1'b1) begin
                got = 1'b1;
                d = rsp_q.data;
            end else begin
                @(posedge clock);
            end
        end
    endtask : send
endmodule : srq_host_model

//--- test/testbench.sv
// Self-checking bench of the status reporting block.
// Assumes the controller model answers within its own bounded wait.
`timescale 1ns/1ps
module testbench;
    import srq_pkg::*;
    localparam logic [15:0] ALL = 16'hffff;
    localparam logic [15:0] B_TRG = 16'(1 << STB_TRG);
    localparam logic [15:0] B_MSG = 16'(1 << STB_MSG);
    localparam logic [15:0] B_MAV = 16'(1 << STB_MAV);
    localparam logic [15:0] B_ESB = 16'(1 << STB_ESB);
    localparam logic [15:0] B_RQS = 16'(1 << STB_RQS);
    localparam logic [15:0] B_OPERATION_READ_QUERY = 16'(1 << STB_OPERATION_READ_QUERY);
    logic clock = 1'b0;
    logic rstn = 1'b0;
    srq_req_t req;
    srq_rsp_t rsp_q;
    srq_std_evt_t std_evt = '0;
    logic after_terminator = 1'b0, trigger_evt = 1'b0, armed_evt = 1'b0;
    logic running = 1'b0, overload = 1'b0, err_valid = 1'b0;
    logic adv_valid = 1'b0, adv_from_dsp = 1'b0, oq_has_data = 1'b0;
    logic [15:0] err_code = 16'h0000, adv_code = 16'h0000;
    logic oq_clear_q, srq_q;
    int fails = 0, checked = 0, clr_seen = 0;

    always #50 clock = ~clock;

    srq_top u_srq_top (.clock(clock), .rstn(rstn), .req(req),
        .after_terminator(after_terminator), .rsp_q(rsp_q),
        .trigger_evt(trigger_evt), .armed_evt(armed_evt), .running(running),
        .overload(overload), .std_evt(std_evt), .err_valid(err_valid),
        .err_code(err_code), .adv_valid(adv_valid),
        .adv_from_dsp(adv_from_dsp), .adv_code(adv_code),
        .oq_has_data(oq_has_data), .oq_clear_q(oq_clear_q), .srq_q(srq_q));
    srq_host_model host (.clock(clock), .req(req), .rsp_q(rsp_q));

    always @(posedge clock) if (oq_clear_q === 1'b1) clr_seen++;

    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic check(input logic [15:0] g, e, input string s);
        checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, s, g, e);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic ask(input srq_cmd_t c, input logic [15:0] m, e);
        logic [15:0] d;
        logic got;
        host.send(c, 16'h0000, d, got);
        if (got !== 1'b1) d = 16'hxxxx;
        check(d & m, e, c.name());
    endtask : ask

    task automatic put(input srq_cmd_t c, input logic [15:0] a);
        logic [15:0] d;
        logic got;
        host.send(c, a, d, got);
    endtask : put

    task automatic std_pulse(input srq_std_evt_t v);
        @(posedge clock);
        std_evt <= v;
        @(posedge clock);
        std_evt <= '0;
        tick(3);
    endtask : std_pulse

    task automatic adv(input logic dsp, input logic [15:0] code);
        @(posedge clock);
        adv_valid <= 1'b1;
        adv_from_dsp <= dsp;
        adv_code <= code;
        @(posedge clock);
        adv_valid <= 1'b0;
        tick(2);
    endtask : adv

    task automatic push_errs(input int n);
        for (int i = 1; i <= n; i++) begin
            @(posedge clock);
            err_valid <= 1'b1;
            err_code <= 16'(i);
        end
        @(posedge clock);
        err_valid <= 1'b0;
        tick(2);
    endtask : push_errs

    task automatic t_std;
        ask(CMD_ESR_Q, ALL, 16'h0080);
        ask(CMD_ESR_Q, ALL, 16'h0000);
        std_pulse(8'h10);
        ask(CMD_STB_Q, B_ESB, 16'h0000);
        ask(CMD_ESR_Q, ALL, 16'h0010);
        put(CMD_ESE_W, 16'h003c);
        ask(CMD_ESE_Q, ALL, 16'h003c);
        for (int i = 2; i < 6; i++) begin
            std_pulse(8'(1 << i));
            ask(CMD_STB_Q, B_ESB, B_ESB);
            ask(CMD_ESR_Q, ALL, 16'(1 << i));
        end
        std_pulse(8'h41);
        ask(CMD_STB_Q, B_ESB, 16'h0000);
        ask(CMD_ESR_Q, ALL, 16'h0041);
        $display("test std done");
    endtask : t_std

    task automatic t_srq;
        put(CMD_SRE_W, 16'h0030);
        ask(CMD_SRE_Q, ALL, 16'h0030);
        put(CMD_SRE_W, B_ESB);
        put(CMD_ESE_W, 16'h0004);
        std_pulse(8'h04);
        check(16'(srq_q), 16'h0001, "srq raised");
        ask(CMD_STB_Q, B_RQS | B_ESB, B_RQS | B_ESB);
        check(16'(srq_q), 16'h0001, "srq kept");
        ask(CMD_SPOLL, B_RQS | B_ESB, B_RQS | B_ESB);
        tick(2);
        check(16'(srq_q), 16'h0000, "srq released");
        ask(CMD_ESR_Q, ALL, 16'h0004);
        std_pulse(8'h04);
        check(16'(srq_q), 16'h0001, "srq again");
        ask(CMD_SPOLL, B_RQS, B_RQS);
        put(CMD_SRE_W, 16'h0000);
        $display("test srq done");
    endtask : t_srq

    task automatic t_op;
        put(CMD_OPERATION_MASK_COMMAND_W, 16'h0828);
        ask(CMD_OPERATION_MASK_COMMAND_Q, ALL, 16'h0828);
        @(posedge clock);
        running <= 1'b1;
        tick(3);
        ask(CMD_STB_Q, B_OPERATION_READ_QUERY, B_OPERATION_READ_QUERY);
        put(CMD_OPERATION_MASK_COMMAND_W, 16'h0000);
        ask(CMD_STB_Q, B_OPERATION_READ_QUERY, 16'h0000);
        put(CMD_OPERATION_MASK_COMMAND_W, 16'h0828);
        running <= 1'b0;
        tick(2);
        ask(CMD_OPERATION_READ_QUERY_Q, ALL, 16'h0008);
        ask(CMD_OPERATION_READ_QUERY_Q, ALL, 16'h0000);
        @(posedge clock);
        overload <= 1'b1;
        repeat (3) @(posedge clock);
        overload <= 1'b0;
        tick(2);
        ask(CMD_OPERATION_READ_QUERY_Q, ALL, 16'h0800);
        ask(CMD_OPERATION_READ_QUERY_Q, ALL, 16'h0000);
        @(posedge clock);
        armed_evt <= 1'b1;
        @(posedge clock);
        armed_evt <= 1'b0;
        tick(3);
        ask(CMD_STB_Q, B_OPERATION_READ_QUERY, B_OPERATION_READ_QUERY);
        ask(CMD_AER_Q, 16'h0001, 16'h0001);
        ask(CMD_AER_Q, 16'h0001, 16'h0000);
        ask(CMD_OPERATION_READ_QUERY_Q, ALL, 16'h0020);
        ask(CMD_OPERATION_READ_QUERY_Q, ALL, 16'h0000);
        $display("test operation done");
    endtask : t_op

    task automatic t_misc;
        @(posedge clock);
        trigger_evt <= 1'b1;
        @(posedge clock);
        trigger_evt <= 1'b0;
        tick(3);
        ask(CMD_STB_Q, B_TRG, B_TRG);
        ask(CMD_STB_Q, B_TRG, B_TRG);
        ask(CMD_TER_Q, 16'h0001, 16'h0001);
        ask(CMD_TER_Q, 16'h0001, 16'h0000);
        ask(CMD_STB_Q, B_TRG, 16'h0000);
        @(posedge clock);
        oq_has_data <= 1'b1;
        tick(1);
        ask(CMD_STB_Q, B_MAV, B_MAV);
        @(posedge clock);
        oq_has_data <= 1'b0;
        tick(1);
        ask(CMD_STB_Q, B_MAV, 16'h0000);
        adv(1'b1, 16'h0011);
        ask(CMD_STB_Q, B_MSG, 16'h0000);
        ask(CMD_DSP_Q, ALL, 16'h0011);
        adv(1'b0, 16'h0022);
        adv(1'b0, 16'h0033);
        ask(CMD_STB_Q, B_MSG, B_MSG);
        ask(CMD_DSP_Q, ALL, 16'h0033);
        $display("test trigger, output and message done");
    endtask : t_misc

    task automatic t_err;
        ask(CMD_ERR_Q, ALL, ERR_NONE);
        push_errs(31);
        for (int i = 1; i < 30; i++) begin
            ask(CMD_ERR_Q, ALL, 16'(i));
        end
        ask(CMD_ERR_Q, ALL, ERR_OVERFLOW);
        ask(CMD_ERR_Q, ALL, ERR_NONE);
        push_errs(2);
        ask(CMD_ERR_Q, ALL, 16'h0001);
        put(CMD_CLS, 16'h0000);
        ask(CMD_ERR_Q, ALL, ERR_NONE);
        $display("test error queue done");
    endtask : t_err

    task automatic t_cls;
        int c0;
        put(CMD_ESE_W, 16'h003c);
        std_pulse(8'h20);
        adv(1'b0, 16'h0044);
        push_errs(1);
        @(posedge clock);
        running <= 1'b1;
        oq_has_data <= 1'b1;
        trigger_evt <= 1'b1;
        @(posedge clock);
        trigger_evt <= 1'b0;
        running <= 1'b0;
        tick(2);
        c0 = clr_seen;
        put(CMD_CLS, 16'h0000);
        tick(2);
        ask(CMD_STB_Q, B_TRG | B_MSG | B_ESB | B_OPERATION_READ_QUERY, 16'h0000);
        ask(CMD_STB_Q, B_MAV, B_MAV);
        check(16'(clr_seen - c0), 16'h0000, "output kept");
        ask(CMD_ESR_Q, ALL, 16'h0000);
        ask(CMD_ERR_Q, ALL, ERR_NONE);
        @(posedge clock);
        after_terminator <= 1'b1;
        put(CMD_CLS, 16'h0000);
        tick(2);
        check(16'(clr_seen - c0), 16'h0001, "output cleared");
        @(posedge clock);
        after_terminator <= 1'b0;
        oq_has_data <= 1'b0;
        $display("test clear done");
    endtask : t_cls

    initial begin
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        tick(1);
        t_std;
        t_srq;
        t_op;
        t_misc;
        t_err;
        t_cls;
        conclude;
    end

    // A hang anywhere ends the run here instead of running forever.
    initial begin
        #2000000;
        fails++;
        $display("mismatch at %0t: run limit reached", $time);
        conclude;
    end
endmodule : testbench
